// file: src/gis_slave.sv
`timescale 1ns/100ps
module gis_slave
	import gis_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input wire logic address_lsb_select,
	input wire logic if_select_n,
	output gis_req_t reg_req,
	input wire logic [7:0] reg_rdata,
	output logic bus_busy
);
	// ****************************************
	// input synchronisers and spike filter
	// ****************************************
	logic [1:0] scl_s_q, sda_s_q;
	logic [1:0] sel_s_q, lsb_s_q;
	logic scl_f_q, sda_f_q;
	logic [7:0] scl_c_q, sda_c_q;
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			scl_s_q <= 2'h3;
			sda_s_q <= 2'h3;
			sel_s_q <= 2'h3;
			lsb_s_q <= 2'h0;
		end else begin
			scl_s_q <= {scl_s_q[0], scl_i};
			sda_s_q <= {sda_s_q[0], sda_i};
			sel_s_q <= {sel_s_q[0], if_select_n};
			lsb_s_q <= {lsb_s_q[0], address_lsb_select};
		end
	end
	// a level must hold longer than the spike width before it is believed
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			scl_f_q <= 1'b1;
			sda_f_q <= 1'b1;
			scl_c_q <= 8'h00;
			sda_c_q <= 8'h00;
		end else begin
			if (scl_s_q[1] == scl_f_q) scl_c_q <= 8'h00;
			else if (scl_c_q == 8'(SPIKE_CYC)) begin
				scl_f_q <= scl_s_q[1];
				scl_c_q <= 8'h00;
			end else scl_c_q <= scl_c_q + 8'h01;
			if (sda_s_q[1] == sda_f_q) sda_c_q <= 8'h00;
			else if (sda_c_q == 8'(SPIKE_CYC)) begin
				sda_f_q <= sda_s_q[1];
				sda_c_q <= 8'h00;
			end else sda_c_q <= sda_c_q + 8'h01;
		end
	end

	// ****************************************
	// bus conditions
	// ****************************************
	logic scl_p_q, sda_p_q;
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_p_q <= scl_f_q;
			sda_p_q <= sda_f_q;
		end
	end
	wire i2c_mode = !sel_s_q[1];
	wire scl_rise = scl_f_q && !scl_p_q;
	wire scl_fall = !scl_f_q && scl_p_q;
	wire start_det = i2c_mode && scl_f_q && scl_p_q && sda_p_q && !sda_f_q;
	wire stop_det = scl_f_q && scl_p_q && !sda_p_q && sda_f_q;
	wire [6:0] own_addr = {ADDR_BASE, lsb_s_q[1]};

	// ****************************************
	// byte engine
	// ****************************************
	gis_state_t st_q;
	logic [3:0] bit_q;
	logic [7:0] sh_q, ptr_q, tx_q;
	logic rw_q, first_q, busy_q, drv_q, nack_q;
	gis_req_t req_q;
	wire ack_slot = (bit_q == BIT_ACK);
	wire addr_match = (sh_q[7:1] == own_addr);
	always_ff @(posedge sys_clk) begin
		if (!rst_n) busy_q <= 1'b0;
		else if (start_det) busy_q <= 1'b1;
		else if (stop_det) busy_q <= 1'b0;
	end
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			st_q <= GIS_IDLE;
			bit_q <= 4'h0;
			sh_q <= 8'h00;
			ptr_q <= PTR_RESET;
			tx_q <= 8'h00;
			rw_q <= 1'b0;
			first_q <= 1'b0;
			drv_q <= 1'b0;
			nack_q <= 1'b0;
			req_q <= '0;
		end else begin
			req_q.we <= 1'b0;
			req_q.re <= 1'b0;
			if (start_det) begin
				st_q <= GIS_ADDR;
				bit_q <= 4'h0;
				drv_q <= 1'b0;
			end else if (stop_det) begin
				st_q <= GIS_IDLE;
				drv_q <= 1'b0;
			end else if (scl_rise && st_q != GIS_IDLE && st_q != GIS_IGN) begin
				if (!ack_slot) sh_q <= {sh_q[6:0], sda_f_q};
				else if (st_q == GIS_RD) nack_q <= sda_f_q;
				// address bits count on rising edges, so the clock fall that closes a start is no bit
				if (st_q == GIS_ADDR) bit_q <= bit_q + 4'h1;
			end else if (scl_fall) begin
				case (st_q)
					GIS_ADDR: begin
						if (bit_q == BIT_ACK) begin
							if (addr_match) begin
								st_q <= GIS_AACK;
								rw_q <= sh_q[0];
								drv_q <= 1'b1;
								bit_q <= BIT_ACK;
								if (sh_q[0]) begin
									req_q.re <= 1'b1;
									req_q.addr <= ptr_q;
								end else first_q <= 1'b1;
							end else st_q <= GIS_IGN;
						end
					end
					GIS_AACK, GIS_WR: begin
						if (ack_slot) begin
							drv_q <= 1'b0;
							bit_q <= 4'h0;
							if (rw_q) begin
								st_q <= GIS_RD;
								tx_q <= reg_rdata;
								drv_q <= !reg_rdata[7];
								ptr_q <= ptr_q + 8'h01;
								bit_q <= 4'h0;
							end else st_q <= GIS_WR;
						end else if (bit_q == 4'h7) begin
							bit_q <= BIT_ACK;
							drv_q <= 1'b1;
							if (first_q) begin
								ptr_q <= sh_q;
								first_q <= 1'b0;
							end else begin
								req_q.we <= 1'b1;
								req_q.addr <= ptr_q;
								req_q.wdata <= sh_q;
								ptr_q <= ptr_q + 8'h01;
							end
						end else bit_q <= bit_q + 4'h1;
					end
					GIS_RD: begin
						if (bit_q == BIT_ACK) begin
							if (nack_q) begin
								st_q <= GIS_IGN;
								drv_q <= 1'b0;
							end else begin
								tx_q <= reg_rdata;
								drv_q <= !reg_rdata[7];
								ptr_q <= ptr_q + 8'h01;
								bit_q <= 4'h0;
							end
						end else if (bit_q == 4'h7) begin
							// master owns the data line through its acknowledge clock
							bit_q <= BIT_ACK;
							drv_q <= 1'b0;
							req_q.re <= 1'b1;
							req_q.addr <= ptr_q;
						end else begin
							drv_q <= !tx_q[3'h6 - bit_q[2:0]];
							bit_q <= bit_q + 4'h1;
						end
					end
					default: ;
				endcase
			end
		end
	end

	// ****************************************
	// pins
	// ****************************************
	assign scl_o = 1'b0;
	assign scl_oe = 1'b0;
	assign sda_o = 1'b0;
	assign sda_oe = drv_q && i2c_mode;
	assign reg_req = req_q;
	assign bus_busy = busy_q;

	// ****************************************
	// checks
	// ****************************************
	a_no_stretch: assert property (@(posedge sys_clk) disable iff (!rst_n) !scl_oe)
		else $error("clock line driven");
	a_ign_released: assert property (@(posedge sys_clk) disable iff (!rst_n)
		st_q == GIS_IGN |-> !sda_oe)
		else $error("data driven while not selected");
	a_busy_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
		start_det |=> bus_busy)
		else $error("busy not set by start");
	a_busy_stop: assert property (@(posedge sys_clk) disable iff (!rst_n)
		stop_det && !start_det |=> !bus_busy)
		else $error("busy not cleared by stop");
	a_start_addr: assert property (@(posedge sys_clk) disable iff (!rst_n)
		start_det |=> st_q == GIS_ADDR && bit_q == 4'h0)
		else $error("start did not open address phase");
	a_match_ack: assert property (@(posedge sys_clk) disable iff (!rst_n)
		scl_fall && st_q == GIS_ADDR && bit_q == BIT_ACK && !start_det && !stop_det && addr_match
		|=> sda_oe == i2c_mode && st_q == GIS_AACK)
		else $error("no ack on own address");
	a_miss_ignore: assert property (@(posedge sys_clk) disable iff (!rst_n)
		scl_fall && st_q == GIS_ADDR && bit_q == BIT_ACK && !start_det && !stop_det && !addr_match
		|=> st_q == GIS_IGN)
		else $error("mismatch not ignored");
	a_wr_ptr_step: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_req.we |-> ptr_q == $past(ptr_q) + 8'h01)
		else $error("write pointer not advanced");
	a_addr_value: assert property (@(posedge sys_clk) disable iff (!rst_n)
		own_addr == (lsb_s_q[1] ? 7'h21 : 7'h20))
		else $error("own address wrong");

	a_sda_low_only: assert property (@(posedge sys_clk) disable iff (!rst_n) !sda_o)
		else $error("data line driven high");

	a_scl_low_only: assert property (@(posedge sys_clk) disable iff (!rst_n) !scl_o)
		else $error("clock line value not low");

	a_idle_released: assert property (@(posedge sys_clk) disable iff (!rst_n)
		st_q == GIS_IDLE |-> !sda_oe)
		else $error("data driven while idle");

	a_stop_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
		stop_det && !start_det |=> st_q == GIS_IDLE && !sda_oe)
		else $error("stop did not end transfer");

	a_start_release: assert property (@(posedge sys_clk) disable iff (!rst_n)
		start_det |=> !sda_oe)
		else $error("data still driven after start");

	a_wr_ack_drive: assert property (@(posedge sys_clk) disable iff (!rst_n)
		scl_fall && st_q == GIS_WR && bit_q == 4'h7 && !start_det && !stop_det
		|=> sda_oe == i2c_mode && bit_q == BIT_ACK)
		else $error("no ack on received byte");

	a_ack_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(st_q == GIS_WR && ack_slot) || st_q == GIS_AACK |-> sda_oe == i2c_mode)
		else $error("ack not held through slot");

	a_rd_ack_release: assert property (@(posedge sys_clk) disable iff (!rst_n)
		st_q == GIS_RD && ack_slot |-> !sda_oe)
		else $error("data driven in master ack slot");

	a_rd_ptr_step: assert property (@(posedge sys_clk) disable iff (!rst_n)
		scl_fall && st_q == GIS_RD && ack_slot && !nack_q && !start_det && !stop_det
		|=> ptr_q == $past(ptr_q) + 8'h01)
		else $error("read pointer not advanced");

	a_rd_nack_end: assert property (@(posedge sys_clk) disable iff (!rst_n)
		scl_fall && st_q == GIS_RD && ack_slot && nack_q && !start_det && !stop_det
		|=> st_q == GIS_IGN && !sda_oe)
		else $error("read not ended by nack");

	a_rd_bit_step: assert property (@(posedge sys_clk) disable iff (!rst_n)
		scl_fall && st_q == GIS_RD && bit_q < 4'h7 && !start_det && !stop_det
		|=> bit_q == $past(bit_q) + 4'h1)
		else $error("read bit count stalled");

	a_bit_range: assert property (@(posedge sys_clk) disable iff (!rst_n)
		bit_q <= BIT_ACK)
		else $error("bit count beyond ack slot");

	a_we_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_req.we |=> !reg_req.we)
		else $error("write request longer than a cycle");

	a_re_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_req.re |=> !reg_req.re)
		else $error("read request longer than a cycle");

	a_we_state: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_req.we |-> st_q == GIS_WR)
		else $error("write request outside write phase");

	a_scl_filter: assert property (@(posedge sys_clk) disable iff (!rst_n)
		scl_c_q <= 8'(SPIKE_CYC))
		else $error("clock filter count overrun");

	a_sda_filter: assert property (@(posedge sys_clk) disable iff (!rst_n)
		sda_c_q <= 8'(SPIKE_CYC))
		else $error("data filter count overrun");

	a_busy_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!bus_busy |-> st_q == GIS_IDLE)
		else $error("engine active while bus free");
endmodule

// file: common/gis_pkg.sv
// Summary of operation
// - answer address 0x20 or 0x21 by pin
// - never hold the clock line low
// - start is data falling while clock high
// - bus busy from start until stop; a start counts only while if_select_n is low
// - first byte: seven address bits, then direction
// - selected only when address bits match
// - ninth clock of every byte is acknowledge
// - receiver holds data low through acknowledge high
// - no limit on bytes per transfer
// - stop is data rising while clock high
// - repeated start begins a new address phase
// - glitches up to 50 ns are ignored
// - works at 100 kHz and 400 kHz
// - read pointer advances as each byte to send is loaded
// - write pointer advances after each byte received past the first, which loads it
package gis_pkg;
	// ****************************************
	// constants
	// ****************************************
	localparam int CLK_MHZ = 250;
	localparam int SPIKE_NS = 50;
	localparam int SPIKE_CYC = (SPIKE_NS * CLK_MHZ) / 1000 + 1;
	localparam int SCL_STD_KHZ = 100;
	localparam int SCL_FAST_KHZ = 400;
	localparam logic [5:0] ADDR_BASE = 6'h10;
	localparam logic [7:0] PTR_RESET = 8'h00;
	localparam logic [3:0] BIT_ACK = 4'h8;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [2:0] {
		GIS_IDLE = 3'b000,
		GIS_ADDR = 3'b001,
		GIS_AACK = 3'b011,
		GIS_WR = 3'b010,
		GIS_RD = 3'b110,
		GIS_IGN = 3'b111
	} gis_state_t;

	typedef struct packed {
		logic we;
		logic re;
		logic [7:0] addr;
		logic [7:0] wdata;
	} gis_req_t;
endpackage

// file: test/gis_master_model.sv
`timescale 1ns/100ps
module gis_master_model(
	input wire logic clk,
	input wire logic sda,
	output logic scl_oe,
	output logic sda_oe
);
	// quarter bit in clocks: each clock phase stays above 600 ns
	localparam int Q = 80;
	initial begin
		scl_oe = 1'b0;
		sda_oe = 1'b0;
	end
	task automatic w();
		repeat (Q) @(posedge clk);
	endtask
	task automatic start();
		w();
		sda_oe <= 1'b0;
		w();
		scl_oe <= 1'b0;
		w();
		sda_oe <= 1'b1;
		w();
		scl_oe <= 1'b1;
	endtask
	task automatic stop();
		w();
		sda_oe <= 1'b1;
		w();
		scl_oe <= 1'b0;
		w();
		sda_oe <= 1'b0;
		w();
	endtask
	// nine clocks, msb first; ninth is the acknowledge slot
	task automatic xfer(input logic [8:0] o, output logic [8:0] i);
		for (int k = 8; k >= 0; k--) begin
			w();
			sda_oe <= !o[k];
			w();
			scl_oe <= 1'b0;
			w();
			i[k] = sda;
			w();
			scl_oe <= 1'b1;
		end
	endtask
	// 40 ns low pulse, shorter than the spike limit
	task automatic glitch();
		sda_oe <= 1'b1;
		repeat (10) @(posedge clk);
		sda_oe <= 1'b0;
	endtask
endmodule

// file: test/testbench.sv
`timescale 1ns/100ps
module testbench;
	import gis_pkg::*;
	logic sys_clk = 0, rst_n = 0, address_lsb_select = 0, if_select_n = 0;
	logic scl_o, scl_oe, sda_o, sda_oe, bus_busy, m_scl_oe, m_sda_oe;
	logic [7:0] reg_rdata = 8'h00, p, d;
	logic [8:0] r;
	gis_req_t reg_req;
	gis_req_t exp_q[$];
	int failures = 0, n_compared = 0, seed = 40066;
	// pull-ups: a released line reads high
	wire scl = !(m_scl_oe | scl_oe);
	wire sda = !(m_sda_oe | sda_oe);
	always #2 sys_clk = !sys_clk;
	gis_slave dut_u(.sys_clk(sys_clk), .rst_n(rst_n), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
		.sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .address_lsb_select(address_lsb_select),
		.if_select_n(if_select_n), .reg_req(reg_req), .reg_rdata(reg_rdata), .bus_busy(bus_busy));
	gis_master_model m_u(.clk(sys_clk), .sda(sda), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));
	// ****************************************
	// compare and close
	// ****************************************
	task automatic chk_val(input logic [7:0] g, input logic [7:0] e);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk_req(input gis_req_t g, input gis_req_t e);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("mismatch at %0t: request %h expected %h", $time, g, e);
		end
	endtask
	task automatic finish_test();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic wr(input logic [7:0] b, input logic ack);
		m_u.xfer({b, 1'b1}, r);
		chk_val(r[0], ack);
	endtask
	// ****************************************
	// register side and watcher
	// ****************************************
	always @(posedge sys_clk) begin
		if (rst_n && reg_req.re === 1'b1)
			reg_rdata <= reg_req.addr ^ 8'h5a;
		if (rst_n)
			chk_val(scl_oe, 1'b0);
		if (rst_n && reg_req.we !== 1'b0)
			chk_req(reg_req, exp_q.size() ? exp_q.pop_front() : '0);
	end
	initial begin
		repeat (90000) @(posedge sys_clk);
		failures++;
		$display("mismatch at %0t: run limit reached", $time);
		finish_test();
	end
	initial begin
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (40) @(posedge sys_clk);
		m_u.glitch();
		repeat (40) @(posedge sys_clk);
		chk_val(bus_busy, 1'b0);
		for (int s = 0; s < 2; s++) begin
			address_lsb_select <= s[0];
			p = $random(seed);
			m_u.start();
			chk_val(bus_busy, 1'b1);
			wr({6'h10, s[0], 1'b0}, 1'b0);
			wr(p, 1'b0);
			for (int j = 0; j < 2; j++) begin
				d = $random(seed);
				exp_q.push_back('{1'b1, 1'b0, p + 8'(j), d});
				wr(d, 1'b0);
			end
			m_u.stop();
			chk_val(bus_busy, 1'b0);
			chk_val(8'(exp_q.size()), 8'h00);
		end
		// a foreign address, then a deselected port
		address_lsb_select <= 1'b0;
		m_u.start();
		wr(8'h42, 1'b1);
		wr(8'h33, 1'b1);
		m_u.stop();
		if_select_n <= 1'b1;
		m_u.start();
		chk_val(bus_busy, 1'b0);
		wr(8'h40, 1'b1);
		m_u.stop();
		if_select_n <= 1'b0;
		p = $random(seed);
		m_u.start();
		wr(8'h40, 1'b0);
		wr(p, 1'b0);
		m_u.start();
		wr(8'h41, 1'b0);
		for (int j = 0; j < 3; j++) begin
			m_u.xfer({8'hff, j == 2}, r);
			chk_val(r[8:1], (p + 8'(j)) ^ 8'h5a);
		end
		m_u.stop();
		chk_val(bus_busy, 1'b0);
		finish_test();
	end
endmodule
